//--- rtl/acp_config_port.sv
module acp_config_port (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic sdi,
  input  wire logic sdoIn,
  output logic      sdoOut,
  output logic      sdoOe,
  input  wire logic configStyleStrap,
  output logic      parallelMode,
  output logic      oneLaneMode,
  output logic      lvdsLowCurrent,
  output logic      powerDown,
  output logic      termEnable,
  output logic      dcsEnable
);
  acp_sync_if #(.W(acp_pkg::PIN_COUNT)) pinBus ();

  logic csS;
  logic sckS;
  logic sdiS;
  logic sdoS;
  logic strapS;
  logic sckRise;
  logic sckFall;

  logic                          sckD_q;
  acp_pkg::acp_phase_t           phase_q,  phase_d;
  logic [acp_pkg::CNT_W-1:0]     cnt_q,    cnt_d;
  logic [acp_pkg::DATA_W-1:0]    shift_q,  shift_d;
  logic [acp_pkg::DATA_W-1:0]    outSh_q,  outSh_d;
  logic                          rd_q,     rd_d;
  logic [acp_pkg::ADDR_W-1:0]    addr_q,   addr_d;
  logic                          sdoDrv_q, sdoDrv_d;
  logic [acp_pkg::DATA_W-1:0]    regs_q [acp_pkg::NUM_REGS];
  logic [acp_pkg::DATA_W-1:0]    regs_d [acp_pkg::NUM_REGS];
  logic [1:0]                    settle_q, settle_d;
  logic                          par_q,    par_d;
  logic                          oneLane_q, oneLane_d;
  logic                          lowCur_q,  lowCur_d;
  logic                          pwrDn_q,   pwrDn_d;
  logic                          term_q,    term_d;
  logic                          dcs_q,     dcs_d;

  // Register index decode, shared by read and write paths
  function automatic logic isMapped(input logic [acp_pkg::ADDR_W-1:0] a);
    isMapped = (a < acp_pkg::ADDR_W'(acp_pkg::NUM_REGS));
  endfunction

  assign pinBus.raw = {configStyleStrap, sdoIn, sdi, sck, csN};

  acp_sync #(.W(acp_pkg::PIN_COUNT)) u_sync (
    .clk  (clk),
    .srst (srst),
    .pins (pinBus.sync)
  );

  assign csS    = pinBus.synced[acp_pkg::PIN_CSN];
  assign sckS   = pinBus.synced[acp_pkg::PIN_SCK];
  assign sdiS   = pinBus.synced[acp_pkg::PIN_SDI];
  assign sdoS   = pinBus.synced[acp_pkg::PIN_SDO];
  assign strapS = pinBus.synced[acp_pkg::PIN_STRAP];

  // Edges found on the sampled link clock
  assign sckRise = sckS & ~sckD_q;
  assign sckFall = ~sckS & sckD_q;

  // Strap caught once after reset; later toggling is ignored
  always_comb begin
    settle_d = settle_q;
    par_d    = par_q;
    if (settle_q != acp_pkg::STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
      if (settle_d == acp_pkg::STRAP_SETTLE) begin
        par_d = strapS;
      end
    end
  end

  // Serial engine next state
  always_comb begin
    phase_d  = phase_q;
    cnt_d    = cnt_q;
    shift_d  = shift_q;
    outSh_d  = outSh_q;
    rd_d     = rd_q;
    addr_d   = addr_q;
    sdoDrv_d = sdoDrv_q;
    for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (par_q || csS) begin
      // Deselect aborts any partial word without touching registers
      phase_d  = acp_pkg::PH_IDLE;
      cnt_d    = '0;
      sdoDrv_d = 1'b0;
    end else begin
      case (phase_q)
        acp_pkg::PH_IDLE: begin
          phase_d = acp_pkg::PH_SHIFT;
          cnt_d   = '0;
          rd_d    = 1'b0;
        end
        acp_pkg::PH_SHIFT: begin
          if (sckRise) begin
            shift_d = {shift_q[acp_pkg::DATA_W-2:0], sdiS};
            cnt_d   = cnt_q + 5'h01;
            if (cnt_q == acp_pkg::CNT_W'(acp_pkg::HDR_BITS - 1)) begin
              rd_d   = shift_q[acp_pkg::DATA_W-2];
              addr_d = {shift_q[acp_pkg::ADDR_W-2:0], sdiS};
              outSh_d = isMapped(addr_d) ? regs_q[addr_d[1:0]] : '0;
            end
            if (cnt_q == acp_pkg::CNT_W'(acp_pkg::WORD_BITS - 1)) begin
              phase_d = acp_pkg::PH_DONE;
              // Commit only on a complete word
              if (!rd_q && isMapped(addr_q)) begin
                regs_d[addr_q[1:0]] = shift_d;
              end
            end
          end else if (sckFall && rd_q &&
                       cnt_q >= acp_pkg::CNT_W'(acp_pkg::HDR_BITS)) begin
            // Pull low for a zero, float for a one
            sdoDrv_d = ~outSh_q[acp_pkg::DATA_W-1];
            outSh_d  = {outSh_q[acp_pkg::DATA_W-2:0], 1'b0};
          end
        end
        acp_pkg::PH_DONE: begin
          // Extra clocks after a full word are ignored
          if (sckFall) begin
            sdoDrv_d = 1'b0;
          end
        end
        default: begin
          phase_d = acp_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Mode outputs: pins in parallel mode (stabilizer forced on), registers in serial mode
  always_comb begin
    if (par_q) begin
      oneLane_d = csS;
      lowCur_d  = sckS;
      pwrDn_d   = sdiS;
      term_d    = sdoS;
      dcs_d     = 1'b1;
    end else begin
      oneLane_d = regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::ONE_LANE_BIT];
      lowCur_d  = regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::LOW_CURR_BIT];
      pwrDn_d   = regs_q[acp_pkg::REG_POWER[1:0]][acp_pkg::PWR_DOWN_BIT];
      term_d    = regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::TERM_ON_BIT];
      dcs_d     = ~regs_q[acp_pkg::REG_CLOCK[1:0]][acp_pkg::DCS_OFF_BIT];
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (srst) begin
      sckD_q    <= 1'b0;
      phase_q   <= acp_pkg::PH_IDLE;
      cnt_q     <= '0;
      shift_q   <= '0;
      outSh_q   <= '0;
      rd_q      <= 1'b0;
      addr_q    <= '0;
      sdoDrv_q  <= 1'b0;
      settle_q  <= 2'h0;
      par_q     <= 1'b0;
      oneLane_q <= 1'b0;
      lowCur_q  <= 1'b0;
      pwrDn_q   <= 1'b0;
      term_q    <= 1'b0;
      dcs_q     <= 1'b1;
      for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= acp_pkg::REG_RESET;
      end
    end else begin
      sckD_q    <= sckS;
      phase_q   <= phase_d;
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      outSh_q   <= outSh_d;
      rd_q      <= rd_d;
      addr_q    <= addr_d;
      sdoDrv_q  <= sdoDrv_d;
      settle_q  <= settle_d;
      par_q     <= par_d;
      oneLane_q <= oneLane_d;
      lowCur_q  <= lowCur_d;
      pwrDn_q   <= pwrDn_d;
      term_q    <= term_d;
      dcs_q     <= dcs_d;
      for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // Open drain: the level driven is always low
  assign sdoOut         = 1'b0;
  assign sdoOe          = sdoDrv_q;
  assign parallelMode   = par_q;
  assign oneLaneMode    = oneLane_q;
  assign lvdsLowCurrent = lowCur_q;
  assign powerDown      = pwrDn_q;
  assign termEnable     = term_q;
  assign dcsEnable      = dcs_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_lastRise;
    phase_q == acp_pkg::PH_SHIFT && !csS && !par_q && sckRise &&
      cnt_q == acp_pkg::CNT_W'(acp_pkg::WORD_BITS - 1);
  endsequence

  sequence s_cutShort;
    phase_q == acp_pkg::PH_SHIFT && csS && cnt_q != '0;
  endsequence

  sequence s_readFall;
    phase_q == acp_pkg::PH_SHIFT && !csS && !par_q && sckFall && rd_q &&
      cnt_q >= acp_pkg::CNT_W'(acp_pkg::HDR_BITS);
  endsequence

  a_write_commit: assert property (
    s_lastRise ##0 (!rd_q && addr_q == acp_pkg::REG_OUTPUT) |=>
      regs_q[2] == {$past(shift_q[6:0]), $past(sdiS)})
    else $error("full write word not committed");

  a_cut_short: assert property (
    s_cutShort |=> (regs_q[0] == $past(regs_q[0]) && regs_q[1] == $past(regs_q[1]) &&
                    regs_q[2] == $past(regs_q[2])))
    else $error("aborted word changed a register");

  a_shift_select: assert property (
    (csS || par_q) |=> cnt_q == '0)
    else $error("bit count moved while deselected");

  a_shift_edge: assert property (
    (phase_q == acp_pkg::PH_SHIFT && !csS && !par_q && !sckRise) |=> cnt_q == $past(cnt_q))
    else $error("bit counted without a rising clock");

  a_readback_bit: assert property (
    s_readFall |=> sdoOe == !$past(outSh_q[7]) ##1 (sdoOe == $past(sdoOe) || sckFall || csS))
    else $error("readback bit wrong after falling edge");

  a_sdo_parallel: assert property (
    par_q |-> (!sdoOe && !sdoOut))
    else $error("readback pin driven in parallel mode");

  a_par_lane: assert property (
    par_q ##1 par_q |-> oneLaneMode == $past(csS) && lvdsLowCurrent == $past(sckS))
    else $error("parallel lane or current select not followed");

  a_par_power: assert property (
    par_q ##1 par_q |-> powerDown == $past(sdiS) && termEnable == $past(sdoS))
    else $error("parallel power-down or termination not followed");

  a_dcs_parallel: assert property (
    par_q |=> dcsEnable)
    else $error("stabilizer disabled in parallel mode");

  a_strap_static: assert property (
    settle_q == acp_pkg::STRAP_SETTLE |=> par_q == $past(par_q))
    else $error("mode changed after strap capture");

  // Readback pin stays released outside the data half of a read
  a_header_quiet: assert property (
    (phase_q == acp_pkg::PH_SHIFT && cnt_q < acp_pkg::CNT_W'(acp_pkg::HDR_BITS)) |-> !sdoOe)
    else $error("readback pin driven during the header");

  a_write_quiet: assert property (
    (phase_q == acp_pkg::PH_SHIFT && !rd_q) |-> !sdoOe)
    else $error("readback pin driven during a write");

  // A host that lets go of select must see the pull-up again at once
  a_deselect_float: assert property (
    (csS || par_q) |=> !sdoOe)
    else $error("readback pin held after deselect");

  // Word end and the clocks that may trail it
  a_word_end: assert property (
    s_lastRise |=> phase_q == acp_pkg::PH_DONE)
    else $error("engine did not stop after a full word");

  a_done_hold: assert property (
    (phase_q == acp_pkg::PH_DONE && !csS && !par_q) |=>
      (phase_q == acp_pkg::PH_DONE && cnt_q == $past(cnt_q)))
    else $error("trailing clocks moved the engine");

  // Registers may only move on the sixteenth rising edge
  a_regs_steady: assert property (
    !(phase_q == acp_pkg::PH_SHIFT && !csS && !par_q && sckRise &&
      cnt_q == acp_pkg::CNT_W'(acp_pkg::WORD_BITS - 1)) |=>
      (regs_q[0] == $past(regs_q[0]) && regs_q[1] == $past(regs_q[1]) &&
       regs_q[2] == $past(regs_q[2])))
    else $error("register changed outside a word end");

  // Serial mode: every mode output follows its register one clock later
  a_serial_modes: assert property (
    !par_q |=>
      oneLaneMode == $past(regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::ONE_LANE_BIT]) &&
      lvdsLowCurrent == $past(regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::LOW_CURR_BIT]) &&
      termEnable == $past(regs_q[acp_pkg::REG_OUTPUT[1:0]][acp_pkg::TERM_ON_BIT]) &&
      powerDown == $past(regs_q[acp_pkg::REG_POWER[1:0]][acp_pkg::PWR_DOWN_BIT]) &&
      dcsEnable == !$past(regs_q[acp_pkg::REG_CLOCK[1:0]][acp_pkg::DCS_OFF_BIT]))
    else $error("serial mode output does not follow its register");

  // Parallel mode keeps the serial engine parked
  a_par_idle: assert property (
    par_q |=> phase_q == acp_pkg::PH_IDLE)
    else $error("serial engine active in parallel mode");

endmodule // acp_config_port

//--- rtl/acp_pkg.sv
// Behaviour
// - Shift only while select held low
// - Serial input sampled on clock rising edge
// - Readback bits shifted out, host latches falling
// - Readback pin only pulls low
// - Strap low serial, high parallel, static
// - Parallel mode: four pins are static inputs
// - Parallel select pin picks one or two lanes
// - Parallel clock pin picks output drive current
// - Parallel data pin powers down the part
// - Parallel readback pin enables output termination
// - Stabilizer always on in parallel mode
package acp_pkg;
  // Serial word layout
  localparam int          ADDR_W     = 7;
  localparam int          DATA_W     = 8;
  localparam int          HDR_BITS   = 8;
  localparam int          WORD_BITS  = 16;
  localparam int          CNT_W      = 5;
  localparam int          NUM_REGS   = 3;
  // Register addresses and field positions
  localparam logic [6:0]  REG_POWER  = 7'h00;
  localparam logic [6:0]  REG_CLOCK  = 7'h01;
  localparam logic [6:0]  REG_OUTPUT = 7'h02;
  localparam int          PWR_DOWN_BIT  = 0;
  localparam int          DCS_OFF_BIT   = 0;
  localparam int          ONE_LANE_BIT  = 0;
  localparam int          LOW_CURR_BIT  = 1;
  localparam int          TERM_ON_BIT   = 2;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  // Synchroniser lane positions
  localparam int          PIN_CSN    = 0;
  localparam int          PIN_SCK    = 1;
  localparam int          PIN_SDI    = 2;
  localparam int          PIN_SDO    = 3;
  localparam int          PIN_STRAP  = 4;
  localparam int          PIN_COUNT  = 5;
  // Strap is caught once the synchroniser has settled
  localparam logic [1:0]  STRAP_SETTLE = 2'h3;
  // Timing
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          T_DO_MAX_NS   = 125;
  localparam int          DO_MAX_CYC    = T_DO_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_SHIFT = 2'b01,
    PH_DONE  = 2'b10
  } acp_phase_t;
endpackage

//--- rtl/acp_sync_if.sv
// Raw pin levels in, synchronised levels out
interface acp_sync_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

//--- rtl/acp_sync.sv
// Two-flop synchroniser for every asynchronous pin
module acp_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic srst,
  acp_sync_if.sync pins
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= pins.raw;
      stable_q <= meta_q;
    end
  end

  assign pins.synced = stable_q;
endmodule // acp_sync

//--- test/acp_host_model.sv
// Serial controller on the far side of the configuration pins
module acp_host_model (
  input  wire logic sdoLine,
  output logic      csN,
  output logic      sck,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: select high, clock parked low
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // One frame of n bits; sel low keeps select high so bits should be ignored
  task automatic xfer(input logic [15:0] w, input int n, input logic sel,
                      output logic [7:0] rd);
    rd = 8'h00;
    csN <= ~sel;
    #62.5;
    for (int i = 15; i > 15 - n; i--) begin
      sdi <= w[i];
      #62.5 sck <= 1'b1;
      #62.5;
      // Latch just before the fall, a full sck period after the fall that launched the bit
      if (i < 8) rd[i] = sdoLine;
      sck <= 1'b0;
    end
    #62.5 csN <= 1'b1;
    sdi <= ~sdi; // Released line flips so a stale bit cannot pass
    #187.5;
  endtask

  // Static levels for parallel control
  task automatic pins(input logic [2:0] v);
    {csN, sck, sdi} <= v;
  endtask
endmodule // acp_host_model

//--- test/tb_adc_config_port.sv
module tb_adc_config_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       srst;
  logic       strap;
  logic       extDrive;
  logic       extLevel;
  logic       sdoOut;
  logic       sdoOe;
  logic       parallelMode;
  logic       oneLaneMode;
  logic       lvdsLowCurrent;
  logic       powerDown;
  logic       termEnable;
  logic       dcsEnable;
  logic [7:0] outs;
  logic [7:0] rd;
  wire logic  csN;
  wire logic  sck;
  wire logic  sdi;
  wire logic  sdoLine;
  int         bad_count;
  int         comparisons;

  // Open-drain wire with pull-up; bench drives it only in parallel mode
  assign sdoLine = (sdoOe && !sdoOut) ? 1'b0 : (extDrive ? extLevel : 1'b1);
  assign outs = {2'b00, parallelMode, oneLaneMode, lvdsLowCurrent, powerDown,
                 termEnable, dcsEnable};

  acp_config_port u_dut (
    .clk(clk), .srst(srst), .csN(csN), .sck(sck), .sdi(sdi), .sdoIn(sdoLine),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .configStyleStrap(strap),
    .parallelMode(parallelMode), .oneLaneMode(oneLaneMode),
    .lvdsLowCurrent(lvdsLowCurrent), .powerDown(powerDown),
    .termEnable(termEnable), .dcsEnable(dcsEnable)
  );

  acp_host_model u_host (.sdoLine(sdoLine), .csN(csN), .sck(sck), .sdi(sdi));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strap is only caught after reset, so a mode change needs a new reset
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    srst  <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic test_serial();
    check(outs, 8'h01);
    u_host.xfer(16'h0207, 16, 1'b1, rd);
    check(outs, 8'h1b);
    u_host.xfer(16'h0001, 16, 1'b1, rd);
    check(outs, 8'h1f);
    u_host.xfer(16'h0101, 16, 1'b1, rd);
    check(outs, 8'h1e);
    u_host.xfer(16'h05ff, 16, 1'b1, rd);
    check(outs, 8'h1e);
    u_host.xfer(16'h8200, 16, 1'b1, rd);
    check(rd, 8'h07);
    u_host.xfer(16'h8100, 16, 1'b1, rd);
    check(rd, 8'h01);
    u_host.xfer(16'h8500, 16, 1'b1, rd);
    check(rd, 8'h00);
    check({7'h00, sdoOe}, 8'h00);
    $display("test_serial done");
  endtask

  task automatic test_refused();
    u_host.xfer(16'h0200, 10, 1'b1, rd);
    check(outs, 8'h1e);
    u_host.xfer(16'h0200, 16, 1'b0, rd);
    check(outs, 8'h1e);
    @(posedge clk);
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    check(outs, 8'h1e);
    $display("test_refused done");
  endtask

  // Every level combination of the four pins
  task automatic test_parallel();
    logic [3:0] v;
    do_reset(1'b1);
    for (int k = 0; k < 16; k++) begin
      v = k[3:0];
      u_host.pins(v[3:1]);
      extDrive <= 1'b1;
      extLevel <= v[0];
      repeat (8) @(posedge clk);
      check(outs, {3'b001, v, 1'b1});
      check({7'h00, sdoOe}, 8'h00);
    end
    $display("test_parallel done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: whole run needs about 21 us
  initial begin
    #300us;
    bad_count++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    strap = 1'b0;
    extDrive = 1'b0;
    extLevel = 1'b0;
    bad_count = 0;
    comparisons = 0;
    do_reset(1'b0);
    test_serial();
    test_refused();
    test_parallel();
    print_verdict();
  end
endmodule // tb_adc_config_port
